// >>> logic/spf_pkg.sv
// shared constants and types of the sensor register port
package spf_pkg;
	// ****************************************
	// bus addressing
	// ****************************************
	localparam logic [6:0] DEV_ADDR = 7'h30;
	localparam logic RW_WRITE = 1'b0;
	localparam logic RW_READ = 1'b1;
	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam int SYS_CLK_HZ = 20_000_000;
	localparam int I2C_STD_HZ = 100_000;
	localparam int I2C_FAST_HZ = 400_000;

	// ****************************************
	// register map
	// ****************************************
	localparam logic [7:0] CTRL_ADDR = 8'h00;
	localparam logic [7:0] ALARM_CFG_ADDR = 8'h78;
	localparam logic [7:0] FLUSH_ADDR = 8'h79;
	localparam logic [7:0] ALERT_MASK_ADDR = 8'h7c;
	localparam logic [7:0] OVF_ADDR = 8'ha4;
	localparam logic [7:0] COUNT_ADDR = 8'ha6;
	localparam logic [7:0] LOW_ADDR = 8'hfe;
	localparam logic [7:0] HIGH_ADDR = 8'hff;
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [7:0] ALARM_CFG_RST = 8'h00;
	localparam logic [7:0] ALERT_MASK_RST = 8'h00;
	localparam int FLUSH_BIT = 0;
	localparam int REG_ON_BIT = 0;
	localparam int OSC_ON_BIT = 1;

	// ****************************************
	// sample queue
	// ****************************************
	localparam int QUEUE_DEPTH = 128;
	localparam int ENTRY_W = 16;
	localparam int SAMPLE_W = 14;
	localparam int EXT_EVENTS = 6;
	localparam int N_EVENTS = 8;

	// ****************************************
	// state encodings
	// ****************************************
	typedef enum logic [8:0] {
		D_IDLE = 9'h001,
		D_ADDR = 9'h002,
		D_ADDR_ACK = 9'h004,
		D_WADDR = 9'h008,
		D_WADDR_ACK = 9'h010,
		D_WDATA = 9'h020,
		D_WDATA_ACK = 9'h040,
		D_RDATA = 9'h080,
		D_RACK = 9'h100
	} spf_dev_state_t;

	typedef enum logic [3:0] {
		H_IDLE = 4'h1,
		H_START = 4'h2,
		H_FRAME = 4'h4,
		H_STOP = 4'h8
	} spf_host_phase_t;

	typedef enum logic [4:0] {
		F_AW = 5'h01,
		F_WA = 5'h02,
		F_WD = 5'h04,
		F_AR = 5'h08,
		F_RD = 5'h10
	} spf_frame_t;
endpackage

// >>> logic/spf_i2c_if.sv
// open-drain two-wire link between host and sensor port
`timescale 1ns/1ps
interface spf_i2c_if;
	logic host_scl_o;
	logic host_scl_oe;
	logic host_sda_o;
	logic host_sda_oe;
	logic dev_sda_o;
	logic dev_sda_oe;
	logic scl;
	logic sda;

	// wired-and with pull-ups
	assign scl = ~(host_scl_oe & ~host_scl_o);
	assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));

	modport dev(input scl, input sda, output dev_sda_o, output dev_sda_oe);
	modport host(input sda, output host_scl_o, output host_scl_oe, output host_sda_o,
		output host_sda_oe);
endinterface

// >>> logic/spf_i2c_dev.sv
// sensor end: two-wire slave, register file and sample queue
// Summary of operation
// - alarm when fill count exceeds alarm level
// - flush command empties queue, holds no state
// - sample into full queue dropped, overflow set
// - read-only fill count from zero to depth
// - high byte read pops one entry
// - empty queue reads zero, no error flag
// - entry holds result shifted left by two
// - marker toggles, holds on first channel
// - low then high byte; pointer loops window
// - access only while chip enable high
// - alert low when masked source active
// - answer bus address 0x30 only
// - works at 100 and 400 kHz
// - write: address, word address, data bytes
// - pointer increments during data acknowledge
// - read data starts at current pointer
// - master turns direction by restart or stop
// - random read: word address, restart, read
// - keep sending while master acknowledges
// - current address read needs no word address
`timescale 1ns/1ps
module spf_i2c_dev
	import spf_pkg::*;
#(
	parameter int DEPTH = QUEUE_DEPTH
) (
	input wire logic clk_sys_in,
	input wire logic rst_in,
	input wire logic enable_in,
	input wire logic clk_link_in,
	spf_i2c_if.dev bus,
	input wire logic sample_valid_in,
	input wire logic [SAMPLE_W-1:0] sample_data_in,
	input wire logic sample_first_in,
	output logic sample_ready_out,
	input wire logic [EXT_EVENTS-1:0] ext_event_in,
	output logic alert_n_out,
	output logic regulator_on_out,
	output logic oscillator_on_out
);
	localparam int PW = $clog2(DEPTH);
	localparam int CW = PW + 1;

	// ****************************************
	// state
	// ****************************************
	typedef struct packed {
		logic req_tgl;
		logic [ENTRY_W-1:0] word;
		logic marker;
		logic ack_s1;
		logic ack_s2;
	} spf_sys_t;

	typedef struct packed {
		logic [DEPTH-1:0][ENTRY_W-1:0] mem;
		logic [PW-1:0] wp;
		logic [PW-1:0] rp;
		logic [CW-1:0] count;
		logic ovf;
		logic [7:0] cfg;
		logic [7:0] mask;
		logic [7:0] ctrl;
		logic alert_n;
		logic scl_s1;
		logic scl_s2;
		logic scl_p;
		logic sda_s1;
		logic sda_s2;
		logic sda_p;
		logic req_s1;
		logic req_s2;
		logic req_p;
		logic [EXT_EVENTS-1:0] ev_s1;
		logic [EXT_EVENTS-1:0] ev_s2;
		spf_dev_state_t state;
		logic [3:0] cnt;
		logic [7:0] shift;
		logic [7:0] tx;
		logic rw;
		logic mack;
		logic [7:0] ptr;
		logic sda_oe;
	} spf_link_t;

	spf_sys_t sr;
	spf_sys_t sn;
	spf_link_t lr;
	spf_link_t ln;
	logic [1:0] rsync;
	logic link_rst;

	function automatic logic [7:0] reg_read(input logic [7:0] a, input spf_link_t s);
		reg_read = 8'h00;
		case (a)
			CTRL_ADDR: reg_read = s.ctrl;
			ALARM_CFG_ADDR: reg_read = s.cfg;
			ALERT_MASK_ADDR: reg_read = s.mask;
			OVF_ADDR: reg_read = {7'h00, s.ovf};
			COUNT_ADDR: reg_read = 8'(s.count);
			LOW_ADDR: reg_read = (s.count == '0) ? 8'h00 : s.mem[s.rp][7:0];
			HIGH_ADDR: reg_read = (s.count == '0) ? 8'h00 : s.mem[s.rp][15:8];
			default: reg_read = 8'h00;
		endcase
	endfunction

	// window end loops back so a block read can drain the queue
	function automatic logic [7:0] next_ptr(input logic [7:0] p);
		next_ptr = (p == HIGH_ADDR) ? LOW_ADDR : p + 8'h01;
	endfunction

	// ****************************************
	// sample side, system clock
	// ****************************************
	assign sample_ready_out = (sr.req_tgl == sr.ack_s2);

	always_comb begin
		sn = sr;
		sn.ack_s1 = lr.req_p;
		sn.ack_s2 = sr.ack_s1;
		if (sample_valid_in && sample_ready_out) begin
			sn.marker = sample_first_in ? sr.marker : ~sr.marker;
			sn.word = {sample_data_in, 1'b0, sn.marker};
			sn.req_tgl = ~sr.req_tgl;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			sr <= '0;
		end else begin
			sr <= sn;
		end
	end

	// ****************************************
	// link side, link clock
	// ****************************************
	// held in reset while chip enable is low
	always_ff @(posedge clk_link_in) begin
		rsync <= {rsync[0], rst_in | ~enable_in};
	end
	assign link_rst = rsync[1];

	logic rise;
	logic fall;
	logic start;
	logic stop;
	logic load;
	logic wr;
	logic flush;
	logic pop;
	logic push;
	logic full;
	logic [N_EVENTS-1:0] events;

	always_comb begin
		ln = lr;
		load = 1'b0;
		wr = 1'b0;
		flush = 1'b0;
		pop = 1'b0;
		// oversampled pins, margin for both bus rates
		ln.scl_s1 = bus.scl;
		ln.scl_s2 = lr.scl_s1;
		ln.scl_p = lr.scl_s2;
		ln.sda_s1 = bus.sda;
		ln.sda_s2 = lr.sda_s1;
		ln.sda_p = lr.sda_s2;
		ln.req_s1 = sr.req_tgl;
		ln.req_s2 = lr.req_s1;
		ln.req_p = lr.req_s2;
		ln.ev_s1 = ext_event_in;
		ln.ev_s2 = lr.ev_s1;
		rise = lr.scl_s2 & ~lr.scl_p;
		fall = ~lr.scl_s2 & lr.scl_p;
		start = lr.scl_s2 & lr.scl_p & lr.sda_p & ~lr.sda_s2;
		stop = lr.scl_s2 & lr.scl_p & ~lr.sda_p & lr.sda_s2;
		if (rise) begin
			ln.shift = {lr.shift[6:0], lr.sda_s2};
			ln.cnt = lr.cnt + 4'h1;
			if (lr.state == D_RACK) begin
				ln.mack = ~lr.sda_s2;
			end
		end
		case (lr.state)
			D_IDLE: begin
			end
			D_ADDR: begin
				if (fall && lr.cnt == BYTE_BITS) begin
					if (lr.shift[7:1] == DEV_ADDR) begin
						ln.rw = lr.shift[0];
						ln.sda_oe = 1'b1;
						ln.state = D_ADDR_ACK;
					end else begin
						ln.state = D_IDLE;
					end
				end
			end
			D_ADDR_ACK: begin
				if (fall) begin
					ln.sda_oe = 1'b0;
					ln.cnt = 4'h0;
					if (lr.rw == RW_READ) begin
						load = 1'b1;
						ln.state = D_RDATA;
					end else begin
						ln.state = D_WADDR;
					end
				end
			end
			D_WADDR: begin
				if (fall && lr.cnt == BYTE_BITS) begin
					ln.ptr = lr.shift;
					ln.sda_oe = 1'b1;
					ln.state = D_WADDR_ACK;
				end
			end
			D_WADDR_ACK, D_WDATA_ACK: begin
				if (fall) begin
					ln.sda_oe = 1'b0;
					ln.cnt = 4'h0;
					ln.state = D_WDATA;
				end
			end
			D_WDATA: begin
				if (fall && lr.cnt == BYTE_BITS) begin
					wr = 1'b1;
					ln.sda_oe = 1'b1;
					ln.state = D_WDATA_ACK;
				end
			end
			D_RDATA: begin
				if (fall) begin
					if (lr.cnt == BYTE_BITS) begin
						ln.sda_oe = 1'b0;
						ln.state = D_RACK;
					end else begin
						ln.sda_oe = ~lr.tx[3'h7 - lr.cnt[2:0]];
					end
				end
			end
			D_RACK: begin
				if (fall) begin
					if (lr.mack) begin
						load = 1'b1;
						ln.cnt = 4'h0;
						ln.state = D_RDATA;
					end else begin
						ln.state = D_IDLE;
					end
				end
			end
			default: ln.state = D_IDLE;
		endcase
		if (stop) begin
			ln.state = D_IDLE;
			ln.sda_oe = 1'b0;
		end
		if (start) begin
			ln.state = D_ADDR;
			ln.cnt = 4'h0;
			ln.sda_oe = 1'b0;
		end
		// register write, pointer steps during the acknowledge
		if (wr) begin
			case (lr.ptr)
				CTRL_ADDR: ln.ctrl = lr.shift;
				ALARM_CFG_ADDR: ln.cfg = lr.shift;
				ALERT_MASK_ADDR: ln.mask = lr.shift;
				FLUSH_ADDR: flush = lr.shift[FLUSH_BIT];
				default: ;
			endcase
			ln.ptr = next_ptr(lr.ptr);
		end
		if (load) begin
			ln.tx = reg_read(lr.ptr, lr);
			pop = (lr.ptr == HIGH_ADDR) && (lr.count != '0);
			ln.ptr = next_ptr(lr.ptr);
			ln.sda_oe = ~ln.tx[7];
		end
		// queue
		push = lr.req_s2 ^ lr.req_p;
		full = (lr.count == CW'(DEPTH));
		if (flush) begin
			ln.wp = '0;
			ln.rp = '0;
			ln.count = '0;
			ln.ovf = 1'b0;
		end else begin
			if (push && !full) begin
				ln.mem[lr.wp] = sr.word;
				ln.wp = lr.wp + 1'b1;
			end
			if (pop) begin
				ln.rp = lr.rp + 1'b1;
			end
			if (push && !full && !pop) begin
				ln.count = lr.count + 1'b1;
			end else if (pop && !(push && !full)) begin
				ln.count = lr.count - 1'b1;
			end
		end
		// overflow set wins over a flush in the same cycle
		if (push && full) begin
			ln.ovf = 1'b1;
		end
		events = {lr.ev_s2[5:4], lr.ovf, (lr.count > CW'(lr.cfg[6:0])), lr.ev_s2[3:0]};
		ln.alert_n = ~|(events & lr.mask);
	end

	always_ff @(posedge clk_link_in) begin
		if (link_rst) begin
			lr <= '0;
			lr.state <= D_IDLE;
			lr.cfg <= ALARM_CFG_RST;
			lr.mask <= ALERT_MASK_RST;
			lr.ctrl <= CTRL_RST;
			lr.alert_n <= 1'b1;
			// pin history starts at the idle level, no false edge after reset
			lr.scl_s1 <= 1'b1;
			lr.scl_s2 <= 1'b1;
			lr.scl_p <= 1'b1;
			lr.sda_s1 <= 1'b1;
			lr.sda_s2 <= 1'b1;
			lr.sda_p <= 1'b1;
		end else begin
			lr <= ln;
		end
	end

	assign bus.dev_sda_o = 1'b0;
	assign bus.dev_sda_oe = lr.sda_oe;
	assign alert_n_out = lr.alert_n;
	assign regulator_on_out = lr.ctrl[REG_ON_BIT];
	assign oscillator_on_out = lr.ctrl[OSC_ON_BIT];
endmodule

// >>> logic/spf_i2c_host.sv
// host end: two-wire bus master driven by a byte command port
`timescale 1ns/1ps
module spf_i2c_host
	import spf_pkg::*;
#(
	parameter int CLK_HZ = SYS_CLK_HZ,
	parameter int BUS_HZ = I2C_STD_HZ
) (
	input wire logic clk_sys_in,
	input wire logic rst_in,
	spf_i2c_if.host bus,
	output logic chip_enable_out,
	input wire logic cmd_valid_in,
	output logic cmd_ready_out,
	input wire logic cmd_read_in,
	input wire logic cmd_with_addr_in,
	input wire logic [7:0] cmd_addr_in,
	input wire logic [8:0] cmd_len_in,
	input wire logic wr_valid_in,
	input wire logic [7:0] wr_data_in,
	output logic wr_ready_out,
	output logic rd_valid_out,
	output logic [7:0] rd_data_out,
	output logic done_out,
	output logic nack_out
);
	// quarter bit period, rounded up so the bus never runs fast
	localparam int QTR = (CLK_HZ + 4 * BUS_HZ - 1) / (4 * BUS_HZ);
	localparam int QW = $clog2(QTR + 1);

	// ****************************************
	// state
	// ****************************************
	typedef struct packed {
		logic en;
		spf_host_phase_t phase;
		spf_frame_t frame;
		logic [QW-1:0] qcnt;
		logic [1:0] q;
		logic [3:0] bit_n;
		logic [7:0] tx;
		logic [7:0] rx;
		logic [7:0] addr;
		logic read;
		logic [8:0] len;
		logic got_ack;
		logic scl_oe;
		logic sda_oe;
		logic sda_s1;
		logic sda_s2;
		logic rd_valid;
		logic [7:0] rd_data;
		logic done;
		logic nack;
	} spf_host_t;

	spf_host_t hr;
	spf_host_t hn;
	logic tick;
	logic stall;
	logic [7:0] txv;

	// commands only once the sensor is enabled
	assign cmd_ready_out = (hr.phase == H_IDLE) && hr.en;
	assign tick = (hr.qcnt == QW'(QTR - 1));
	assign wr_ready_out = (hr.phase == H_FRAME) && (hr.frame == F_WD) && (hr.bit_n == 4'h0) &&
		(hr.q == 2'h0) && tick;
	assign stall = wr_ready_out && !wr_valid_in;
	assign txv = wr_ready_out ? wr_data_in : hr.tx;

	always_comb begin
		hn = hr;
		hn.en = 1'b1;
		hn.rd_valid = 1'b0;
		hn.done = 1'b0;
		hn.sda_s1 = bus.sda;
		hn.sda_s2 = hr.sda_s1;
		hn.qcnt = (hr.phase == H_IDLE || tick) ? '0 : hr.qcnt + 1'b1;
		if (tick && !stall) begin
			hn.q = hr.q + 2'h1;
		end
		case (hr.phase)
			H_IDLE: begin
				hn.q = 2'h0;
				if (cmd_valid_in && cmd_ready_out) begin
					hn.read = cmd_read_in;
					hn.addr = cmd_addr_in;
					hn.len = cmd_len_in;
					hn.nack = 1'b0;
					hn.phase = H_START;
					if (cmd_read_in && !cmd_with_addr_in) begin
						hn.frame = F_AR;
						hn.tx = {DEV_ADDR, RW_READ};
					end else begin
						hn.frame = F_AW;
						hn.tx = {DEV_ADDR, RW_WRITE};
					end
				end
			end
			H_START: begin
				if (tick) begin
					case (hr.q)
						2'h0: hn.sda_oe = 1'b0;
						2'h1: hn.scl_oe = 1'b0;
						2'h2: hn.sda_oe = 1'b1;
						default: begin
							hn.scl_oe = 1'b1;
							hn.bit_n = 4'h0;
							hn.phase = H_FRAME;
						end
					endcase
				end
			end
			H_STOP: begin
				if (tick) begin
					case (hr.q)
						2'h0: hn.sda_oe = 1'b1;
						2'h1: hn.scl_oe = 1'b0;
						2'h2: hn.sda_oe = 1'b0;
						default: begin
							hn.phase = H_IDLE;
							hn.done = 1'b1;
						end
					endcase
				end
			end
			H_FRAME: begin
				if (tick && !stall) begin
					case (hr.q)
						2'h0: begin
							if (wr_ready_out) begin
								hn.tx = wr_data_in;
							end
							if (hr.bit_n < BYTE_BITS) begin
								hn.sda_oe = (hr.frame != F_RD) && !txv[3'h7 - hr.bit_n[2:0]];
							end else begin
								// acknowledge all but the last read byte
								hn.sda_oe = (hr.frame == F_RD) && (hr.len != 9'h001);
							end
						end
						2'h1: hn.scl_oe = 1'b0;
						2'h2: begin
							if (hr.bit_n < BYTE_BITS) begin
								hn.rx = {hr.rx[6:0], hr.sda_s2};
							end else begin
								hn.got_ack = ~hr.sda_s2;
							end
						end
						default: begin
							hn.scl_oe = 1'b1;
							hn.bit_n = hr.bit_n + 4'h1;
							if (hr.bit_n == BYTE_BITS) begin
								hn.bit_n = 4'h0;
								if (!hr.got_ack && hr.frame != F_RD) begin
									hn.nack = 1'b1;
									hn.phase = H_STOP;
								end else begin
									case (hr.frame)
										F_AW: begin
											hn.frame = F_WA;
											hn.tx = hr.addr;
										end
										F_WA: begin
											if (hr.read) begin
												hn.phase = H_START;
												hn.frame = F_AR;
												hn.tx = {DEV_ADDR, RW_READ};
											end else if (hr.len == 9'h000) begin
												hn.phase = H_STOP;
											end else begin
												hn.frame = F_WD;
											end
										end
										F_WD: begin
											hn.len = hr.len - 9'h001;
											if (hr.len == 9'h001) begin
												hn.phase = H_STOP;
											end
										end
										F_AR: begin
											if (hr.len == 9'h000) begin
												hn.phase = H_STOP;
											end else begin
												hn.frame = F_RD;
											end
										end
										default: begin
											hn.rd_valid = 1'b1;
											hn.rd_data = hr.rx;
											hn.len = hr.len - 9'h001;
											if (hr.len == 9'h001) begin
												hn.phase = H_STOP;
											end
										end
									endcase
								end
							end
						end
					endcase
				end
			end
			default: hn.phase = H_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			hr <= '0;
			hr.phase <= H_IDLE;
			hr.frame <= F_AW;
		end else begin
			hr <= hn;
		end
	end

	assign bus.host_scl_o = 1'b0;
	assign bus.host_scl_oe = hr.scl_oe;
	assign bus.host_sda_o = 1'b0;
	assign bus.host_sda_oe = hr.sda_oe;
	assign chip_enable_out = hr.en;
	assign rd_valid_out = hr.rd_valid;
	assign rd_data_out = hr.rd_data;
	assign done_out = hr.done;
	assign nack_out = hr.nack;
endmodule

// >>> test/spf_i2c_props.sv
// assertions on the two-wire link between host and sensor ends
`timescale 1ns/1ps
module spf_i2c_props
	import spf_pkg::*;
(
	input wire logic clk_sys_in,
	input wire logic rst_in,
	input wire logic scl,
	input wire logic sda,
	input wire logic host_sda_oe,
	input wire logic dev_sda_oe
);
	logic scl_q, sda_q, busy, first, rw, hit, rise, start, stop;
	logic [3:0] bits;
	logic [7:0] shreg;

	assign rise = scl & ~scl_q;
	assign start = scl & scl_q & sda_q & ~sda;
	assign stop = scl & scl_q & ~sda_q & sda;

	// ****
	// frame tracker
	// ****
	always_ff @(posedge clk_sys_in) begin
		scl_q <= scl;
		sda_q <= sda;
		if (rst_in || stop) begin
			busy <= 1'b0;
			bits <= 4'h0;
			first <= 1'b0;
			rw <= 1'b0;
			hit <= 1'b0;
		end else if (start) begin
			busy <= 1'b1;
			bits <= 4'h0;
			first <= 1'b1;
		end else if (rise && bits == 4'h8) begin
			bits <= 4'h0;
			first <= 1'b0;
			if (first) begin
				rw <= shreg[0];
				hit <= shreg[7:1] == DEV_ADDR;
			end
		end else if (rise) begin
			bits <= bits + 4'h1;
			shreg <= {shreg[6:0], sda};
		end
	end

	default clocking cb @(posedge clk_sys_in);
	endclocking
	default disable iff (rst_in);

	a_dev_edge_low: assert property ($changed(dev_sda_oe) |-> !scl)
		else $error("sensor data moved while clock high");
	a_quiet_idle: assert property (!busy |-> !dev_sda_oe)
		else $error("sensor pulls data line on idle bus");
	a_addr_slot: assert property (first && scl && dev_sda_oe |-> bits == 4'h8)
		else $error("sensor drives during address bits");
	a_own_ack: assert property (rise && first && bits == 4'h8 && shreg[7:1] == DEV_ADDR |-> !sda)
		else $error("own address not acknowledged");
	a_write_ack: assert property (rise && !first && bits == 4'h8 && hit && !rw |-> !sda)
		else $error("written byte not acknowledged");
	a_ack_held: assert property (rise && bits == 4'h8 && dev_sda_oe |-> dev_sda_oe[*8])
		else $error("acknowledge dropped while clock high");
	a_scl_high_min: assert property (rise |-> scl[*8])
		else $error("clock high phase too short");
	a_host_start: assert property (start |-> host_sda_oe)
		else $error("start not made by host");
endmodule

// >>> test/tb_i2c_port_with_sample_fifo.sv
// self-checking bench: host and sensor ends joined on one link
`timescale 1ns/1ps
module tb_i2c_port_with_sample_fifo
	import spf_pkg::*;
;
	logic clk_sys_in = 1'b0, clk_link_in = 1'b0, rst_in = 1'b1, chip_en;
	logic cmd_valid_in = 1'b0, cmd_read_in = 1'b0, cmd_with_addr_in = 1'b0, cmd_ready_out;
	logic [7:0] cmd_addr_in = 8'h00, wr_data_in = 8'h00, rd_data_out;
	logic [8:0] cmd_len_in = 9'h000;
	logic wr_valid_in = 1'b0, wr_ready_out, rd_valid_out, done_out, nack_out;
	logic sample_valid_in = 1'b0, sample_first_in = 1'b0, sample_ready_out;
	logic [SAMPLE_W-1:0] sample_data_in = '0;
	logic [EXT_EVENTS-1:0] ext_event_in = '0;
	logic alert_n_out, regulator_on_out, oscillator_on_out;
	logic [7:0] wq[$];
	logic [7:0] rq[$];
	int error_cnt = 0;
	int checked = 0;

	spf_i2c_if bus();
	spf_i2c_host #(.BUS_HZ(I2C_FAST_HZ)) spf_i2c_host_inst (.clk_sys_in(clk_sys_in),
		.rst_in(rst_in), .bus(bus.host), .chip_enable_out(chip_en), .cmd_valid_in(cmd_valid_in),
		.cmd_ready_out(cmd_ready_out), .cmd_read_in(cmd_read_in), .cmd_addr_in(cmd_addr_in),
		.cmd_with_addr_in(cmd_with_addr_in), .cmd_len_in(cmd_len_in), .wr_valid_in(wr_valid_in),
		.wr_data_in(wr_data_in), .wr_ready_out(wr_ready_out), .rd_valid_out(rd_valid_out),
		.rd_data_out(rd_data_out), .done_out(done_out), .nack_out(nack_out));
	spf_i2c_dev spf_i2c_dev_inst (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .enable_in(chip_en),
		.clk_link_in(clk_link_in), .bus(bus.dev), .sample_valid_in(sample_valid_in),
		.sample_data_in(sample_data_in), .sample_first_in(sample_first_in),
		.sample_ready_out(sample_ready_out), .ext_event_in(ext_event_in),
		.alert_n_out(alert_n_out), .regulator_on_out(regulator_on_out),
		.oscillator_on_out(oscillator_on_out));
	spf_i2c_props spf_i2c_props_inst (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .scl(bus.scl),
		.sda(bus.sda), .host_sda_oe(bus.host_sda_oe), .dev_sda_oe(bus.dev_sda_oe));

	always #25 clk_sys_in = ~clk_sys_in;
	initial begin
		#7;
		forever #15 clk_link_in = ~clk_link_in;
	end

	// ****
	// shared tasks
	// ****
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic stop_test();
		if (error_cnt == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic xfer(input logic rd, input logic wa, input logic [7:0] a, input logic [8:0] n);
		int t;
		logic tk, wt, fin;
		fin = 1'b0;
		rq = {};
		@(posedge clk_sys_in);
		cmd_valid_in <= 1'b1;
		cmd_read_in <= rd;
		cmd_with_addr_in <= wa;
		cmd_addr_in <= a;
		cmd_len_in <= n;
		for (t = 0; t < 20000 && !fin; t++) begin
			wr_valid_in <= wq.size() > 0;
			wr_data_in <= (wq.size() > 0) ? wq[0] : 8'h00;
			@(negedge clk_sys_in);
			tk = cmd_ready_out === 1'b1 && cmd_valid_in === 1'b1;
			wt = wr_ready_out === 1'b1 && wr_valid_in === 1'b1;
			fin = done_out === 1'b1;
			if (rd_valid_out === 1'b1)
				rq.push_back(rd_data_out);
			@(posedge clk_sys_in);
			if (tk)
				cmd_valid_in <= 1'b0;
			if (wt)
				wq.delete(0);
		end
		chk({15'h0000, fin}, 16'h0001);
		if (!fin)
			stop_test();
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		wq.push_back(d);
		xfer(1'b0, 1'b1, a, 9'h001);
		chk({15'h0000, nack_out}, 16'h0000);
	endtask

	task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
		xfer(1'b1, 1'b1, a, 9'h001);
		chk({8'h00, rq[0]}, {8'h00, exp});
	endtask

	task automatic push(input logic [SAMPLE_W-1:0] d, input logic f);
		int t;
		sample_valid_in <= 1'b1;
		sample_data_in <= d;
		sample_first_in <= f;
		for (t = 0; t < 100; t++) begin
			@(negedge clk_sys_in);
			if (sample_ready_out === 1'b1)
				break;
			@(posedge clk_sys_in);
		end
		@(posedge clk_sys_in);
		sample_valid_in <= 1'b0;
		@(posedge clk_sys_in);
		chk({15'h0000, t < 100}, 16'h0001);
		if (t >= 100)
			stop_test();
	endtask

	task automatic alert_is(input logic e);
		int t;
		for (t = 0; t < 40; t++) begin
			@(negedge clk_sys_in);
			if (alert_n_out === e)
				break;
		end
		chk({15'h0000, alert_n_out}, {15'h0000, e});
		@(posedge clk_sys_in);
	endtask

	// ****
	// scenarios
	// ****
	task automatic t_reset();
		rchk(ALARM_CFG_ADDR, ALARM_CFG_RST);
		rchk(OVF_ADDR, 8'h00);
		wr(COUNT_ADDR, 8'h55);
		rchk(COUNT_ADDR, 8'h00);
		wr(CTRL_ADDR, 8'h01);
		chk({15'h0000, regulator_on_out}, 16'h0001);
		wr(CTRL_ADDR, 8'h03);
		chk({14'h0000, oscillator_on_out, regulator_on_out}, 16'h0003);
	endtask

	task automatic t_fill();
		logic m;
		logic [SAMPLE_W-1:0] smp [3];
		smp = '{14'h3abc, 14'h0123, 14'h2001};
		wq = {8'h02, 8'h00};
		xfer(1'b0, 1'b1, ALARM_CFG_ADDR, 9'h002);
		rchk(ALARM_CFG_ADDR, 8'h02);
		wr(ALERT_MASK_ADDR, 8'h10);
		push(smp[0], 1'b0);
		push(smp[1], 1'b1);
		push(smp[2], 1'b0);
		rchk(COUNT_ADDR, 8'h03);
		alert_is(1'b0);
		xfer(1'b1, 1'b1, LOW_ADDR, 9'h002);
		m = rq[0][0];
		chk({rq[1], rq[0] & 8'hfe}, {smp[0], 2'b00});
		alert_is(1'b1);
		xfer(1'b1, 1'b0, 8'h00, 9'h004);
		chk({rq[1], rq[0] & 8'hfe}, {smp[1], 2'b00});
		chk({rq[3], rq[2] & 8'hfe}, {smp[2], 2'b00});
		chk({14'h0000, rq[2][0], rq[0][0]}, {14'h0000, ~m, m});
		rchk(COUNT_ADDR, 8'h00);
	endtask

	task automatic t_flush();
		push(14'h1555, 1'b0);
		xfer(1'b1, 1'b1, LOW_ADDR, 9'h001);
		rchk(COUNT_ADDR, 8'h01);
		wr(FLUSH_ADDR, 8'h01);
		rchk(COUNT_ADDR, 8'h00);
		rchk(FLUSH_ADDR, 8'h00);
		xfer(1'b1, 1'b1, LOW_ADDR, 9'h002);
		chk({rq[1], rq[0]}, 16'h0000);
		rchk(OVF_ADDR, 8'h00);
	endtask

	task automatic t_ovf();
		int i;
		for (i = 0; i < QUEUE_DEPTH + 1; i++)
			push(14'(i), 1'b0);
		rchk(COUNT_ADDR, 8'h80);
		rchk(OVF_ADDR, 8'h01);
		wr(ALERT_MASK_ADDR, 8'h20);
		alert_is(1'b0);
		wr(FLUSH_ADDR, 8'h01);
		rchk(OVF_ADDR, 8'h00);
		alert_is(1'b1);
	endtask

	task automatic t_event();
		int i;
		wr(ALERT_MASK_ADDR, 8'hcf);
		for (i = 0; i < EXT_EVENTS; i++) begin
			ext_event_in <= EXT_EVENTS'(1 << i);
			alert_is(1'b0);
			ext_event_in <= '0;
			alert_is(1'b1);
		end
		ext_event_in <= '1;
		wr(ALERT_MASK_ADDR, 8'h30);
		alert_is(1'b1);
	endtask

	initial begin
		repeat (12) @(posedge clk_sys_in);
		rst_in <= 1'b0;
		repeat (8) @(posedge clk_sys_in);
		t_reset();
		t_fill();
		t_flush();
		t_ovf();
		t_event();
		stop_test();
	end
endmodule
